/* File: ccr_regs.sv */
// charger control register bank with link-side access port and fault logic
`timescale 1ns/1ps
module ccr_regs #(
    parameter logic [31:0] DEGLITCH_SLOW_CYC =
        32'(ccr_pkg::DEGLITCH_SLOW_MS * 1000000 / ccr_pkg::CLK_NS),
    parameter logic [31:0] RECOVER_CYC = 32'(ccr_pkg::RECOVER_US * 1000 / ccr_pkg::CLK_NS),
    parameter logic [31:0] WD_SHORT_CYC =
        32'(ccr_pkg::WD_SHORT_S * ccr_pkg::NS_PER_S / ccr_pkg::CLK_NS),
    parameter logic [31:0] WD_MID_CYC =
        32'(ccr_pkg::WD_MID_S * ccr_pkg::NS_PER_S / ccr_pkg::CLK_NS),
    parameter logic [31:0] WD_LONG_CYC =
        32'(ccr_pkg::WD_LONG_S * ccr_pkg::NS_PER_S / ccr_pkg::CLK_NS)
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic link_wr,
    input wire logic link_rd,
    input wire logic [7:0] link_addr,
    input wire logic [15:0] link_wdata,
    output logic [15:0] link_rdata,
    output logic link_done,
    output logic link_busy,
    input wire logic [10:0] hw_fault_event,
    input wire logic temp_cool,
    input wire logic adapter_level,
    input wire logic sleep_mode,
    output logic input_good_pin,
    output logic charge_enable,
    output logic soft_start,
    output logic watchdog_expired,
    output logic battery_switch,
    output logic input_switch,
    output logic switching_rate_select,
    output logic spread_freq_enable,
    output logic emi_shift_direction,
    output logic [1:0] recirc_current_limit,
    output logic monitor_source_select,
    output logic [7:0] current_setting_field,
    output logic [13:0] charge_target_field,
    output logic [6:0] input_limit_field
);
    // ==========================================
    // state types
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic busy;
        logic req_tgl;
        logic is_wr;
        logic [7:0] addr;
        logic [15:0] wdata;
        logic ack_s1;
        logic ack_s2;
        logic ack_seen;
        logic [15:0] rdata;
        logic done;
    } ccr_link_t;

    typedef struct packed {
        logic [ccr_pkg::PIN_W-1:0] pin_s1;
        logic [ccr_pkg::PIN_W-1:0] pin_s2;
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic ack_tgl;
        logic [15:0] rdata_hold;
        logic [15:0] options;
        logic [15:0] fault;
        logic [15:0] current;
        logic [15:0] target;
        logic [15:0] ilimit;
        logic limit_set_pin_bad;
        logic [31:0] dg_cnt;
        logic input_good;
        logic [31:0] wd_cnt;
        logic wd_exp;
        logic [31:0] recov;
        logic charge_en;
        logic soft_start;
        logic bat_sw;
        logic in_sw;
    } ccr_core_t;

    ccr_link_t l_q;
    ccr_link_t l_d;
    ccr_core_t c_q;
    ccr_core_t c_d;
    logic go;
    logic wr_go;
    logic clr;
    logic [10:0] ev;
    logic limit_set_pin_out;

    // ==========================================
    // link domain: request capture and answer
    always_comb
    begin
        l_d = l_q;
        l_d.rst_s1 = sys_rst;
        l_d.rst_s2 = l_q.rst_s1;
        l_d.ack_s1 = c_q.ack_tgl;
        l_d.ack_s2 = l_q.ack_s1;
        l_d.done = 1'b0;
        if (l_q.rst_s2)
        begin
            l_d.busy = 1'b0;
            l_d.req_tgl = 1'b0;
            l_d.is_wr = 1'b0;
            l_d.addr = 8'h00;
            l_d.wdata = 16'h0000;
            l_d.ack_seen = 1'b0;
            l_d.rdata = 16'h0000;
        end
        else if (l_q.busy && (l_q.ack_s2 != l_q.ack_seen))
        begin
            // core finished; read word is stable in its hold register
            l_d.ack_seen = l_q.ack_s2;
            l_d.busy = 1'b0;
            l_d.done = 1'b1;
            l_d.rdata = c_q.rdata_hold;
        end
        else if (!l_q.busy && (link_wr || link_rd))
        begin
            l_d.busy = 1'b1;
            l_d.req_tgl = ~l_q.req_tgl;
            l_d.is_wr = link_wr;
            l_d.addr = link_addr;
            l_d.wdata = link_wdata;
        end
    end

    // link domain register
    always_ff @(posedge link_clk)
    begin
        l_q <= l_d;
    end

    assign link_rdata = l_q.rdata;
    assign link_done = l_q.done;
    assign link_busy = l_q.busy;

    // ==========================================
    // core request decode and hardware events
    assign go = c_q.req_s2 != c_q.req_seen;
    assign wr_go = go && l_q.is_wr;
    assign clr = wr_go && (l_q.addr == ccr_pkg::OFS_OPTIONS) && l_q.wdata[ccr_pkg::BIT_CLEAR];
    assign ev = c_q.pin_s2[10:0];
    assign limit_set_pin_out = (l_q.wdata < ccr_pkg::ILIMIT_MIN) || (l_q.wdata > ccr_pkg::ILIMIT_MAX);

    // read mux, unmapped addresses answer zero
    function automatic logic [15:0] rd_word(input ccr_core_t s, input logic [7:0] a);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            ccr_pkg::OFS_OPTIONS: v = s.options;
            ccr_pkg::OFS_FAULT: v = s.fault;
            ccr_pkg::OFS_CURRENT: v = s.current;
            ccr_pkg::OFS_TARGET: v = s.target;
            ccr_pkg::OFS_ILIMIT: v = s.ilimit;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // ==========================================
    // core next state
    always_comb
    begin
        logic [31:0] dg_tgt;
        logic [31:0] wd_lim;
        c_d = c_q;
        dg_tgt = 32'h0;
        wd_lim = 32'h0;
        c_d.pin_s1 = {sleep_mode, adapter_level, temp_cool, hw_fault_event};
        c_d.pin_s2 = c_q.pin_s1;
        c_d.req_s1 = l_q.req_tgl;
        c_d.req_s2 = c_q.req_s1;
        c_d.req_seen = c_q.req_s2;
        if (go)
        begin
            c_d.ack_tgl = ~c_q.ack_tgl;
            if (!l_q.is_wr)
                c_d.rdata_hold = rd_word(c_q, l_q.addr);
        end
        // register writes; fault flags offset is read only
        if (wr_go)
        begin
            case (l_q.addr)
                ccr_pkg::OFS_OPTIONS:
                    // reserved bit and self-clearing trigger kept zero
                    c_d.options = l_q.wdata & ccr_pkg::OPTIONS_WMASK;
                ccr_pkg::OFS_CURRENT:
                    c_d.current = l_q.wdata & ccr_pkg::CURRENT_MASK;
                ccr_pkg::OFS_TARGET:
                    c_d.target = l_q.wdata & ccr_pkg::TARGET_MASK;
                ccr_pkg::OFS_ILIMIT:
                begin
                    c_d.ilimit = limit_set_pin_out ? 16'h0000 : (l_q.wdata & ccr_pkg::ILIMIT_MASK);
                    c_d.limit_set_pin_bad = limit_set_pin_out;
                end
                default: ;
            endcase
        end
        // sticky flags except thermal, released once cool; set wins over clear
        c_d.fault = ((c_q.fault & ~{16{clr}}) | {5'h00, ev}) & ccr_pkg::FAULT_MASK;
        if (c_q.pin_s2[ccr_pkg::PIN_COOL] && !ev[ccr_pkg::FLT_TEMP])
            c_d.fault[ccr_pkg::FLT_TEMP] = 1'b0;
        dg_tgt = c_q.options[ccr_pkg::BIT_DEGLITCH] ?
            32'(ccr_pkg::DEGLITCH_FAST_CYC) : DEGLITCH_SLOW_CYC;
        if (!c_q.pin_s2[ccr_pkg::PIN_ADAPTER])
        begin
            c_d.dg_cnt = 32'h0;
            c_d.input_good = 1'b0;
        end
        else if (!c_q.input_good)
        begin
            if (c_q.dg_cnt >= dg_tgt)
                c_d.input_good = 1'b1;
            else
                c_d.dg_cnt = c_q.dg_cnt + 32'h1;
        end
        case (c_q.options[ccr_pkg::WD_HI:ccr_pkg::WD_LO])
            2'b01: wd_lim = WD_SHORT_CYC;
            2'b10: wd_lim = WD_MID_CYC;
            2'b11: wd_lim = WD_LONG_CYC;
            default: wd_lim = 32'h0;
        endcase
        // any host write restarts the watchdog
        if ((wd_lim == 32'h0) || wr_go)
        begin
            c_d.wd_cnt = 32'h0;
            c_d.wd_exp = 1'b0;
        end
        else if (!c_q.wd_exp)
        begin
            if (c_q.wd_cnt >= wd_lim - 32'h1)
                c_d.wd_exp = 1'b1;
            else
                c_d.wd_cnt = c_q.wd_cnt + 32'h1;
        end
        // recovery delay after overcurrent or thermal stop
        if (ev[ccr_pkg::FLT_IN_OC] || c_q.fault[ccr_pkg::FLT_TEMP])
            c_d.recov = RECOVER_CYC;
        else if (c_q.recov != 32'h0)
            c_d.recov = c_q.recov - 32'h1;
        c_d.charge_en = !c_q.options[ccr_pkg::BIT_BLOCK] && !c_q.limit_set_pin_bad && !c_q.wd_exp &&
            c_q.input_good && (c_q.recov == 32'h0) && !ev[ccr_pkg::FLT_IN_OC] &&
            !c_q.fault[ccr_pkg::FLT_TEMP];
        c_d.soft_start = c_d.charge_en && !c_q.charge_en;
        if (c_q.options[ccr_pkg::BIT_MANUAL])
        begin
            c_d.bat_sw = c_q.options[ccr_pkg::BIT_BAT_DRV];
            c_d.in_sw = c_q.options[ccr_pkg::BIT_IN_DRV];
        end
        // sleep keeps battery path as selected
        else if (c_q.pin_s2[ccr_pkg::PIN_SLEEP])
        begin
            c_d.bat_sw = c_q.options[ccr_pkg::BIT_SLEEP_BAT];
            c_d.in_sw = 1'b0;
        end
        else
        begin
            c_d.bat_sw = !c_q.input_good;
            c_d.in_sw = c_q.input_good;
        end
        if (sys_rst)
        begin
            c_d = '0;
            c_d.options = ccr_pkg::RST_OPTIONS;
            c_d.fault = ccr_pkg::RST_FAULT;
            c_d.current = ccr_pkg::RST_CURRENT;
            c_d.target = ccr_pkg::RST_TARGET;
            c_d.ilimit = ccr_pkg::RST_ILIMIT;
        end
    end

    // core register
    always_ff @(posedge clk)
    begin
        c_q <= c_d;
    end

    // ==========================================
    // outputs straight from core flops
    assign input_good_pin = c_q.input_good;
    assign charge_enable = c_q.charge_en;
    assign soft_start = c_q.soft_start;
    assign watchdog_expired = c_q.wd_exp;
    assign battery_switch = c_q.bat_sw;
    assign input_switch = c_q.in_sw;
    assign switching_rate_select = c_q.options[ccr_pkg::BIT_RATE];
    assign spread_freq_enable = c_q.options[ccr_pkg::BIT_SPREAD];
    assign emi_shift_direction = c_q.options[ccr_pkg::BIT_EMI_DIR];
    assign recirc_current_limit = c_q.options[ccr_pkg::RECIRC_HI:ccr_pkg::RECIRC_LO];
    assign monitor_source_select = c_q.options[ccr_pkg::BIT_MONITOR];
    assign current_setting_field = c_q.current[13:6];
    assign charge_target_field = c_q.target[14:1];
    assign input_limit_field = c_q.ilimit[13:7];

    // ==========================================
    // checks
    property p_reserved_zero;
        @(posedge clk) disable iff (sys_rst)
        (c_q.fault[15:11] == 5'h00) && !c_q.options[ccr_pkg::BIT_RSVD];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits not zero");

    property p_fault_clear;
        @(posedge clk) disable iff (sys_rst)
        clr && (ev == 11'h000) |=> (c_q.fault == 16'h0000) && !c_q.options[ccr_pkg::BIT_CLEAR];
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("fault clear did not empty flags");

    property p_fault_ro;
        @(posedge clk) disable iff (sys_rst)
        wr_go && (l_q.addr == ccr_pkg::OFS_FAULT) && (ev == 11'h000) &&
            !c_q.pin_s2[ccr_pkg::PIN_COOL] |=> c_q.fault == $past(c_q.fault);
    endproperty
    a_fault_ro: assert property (p_fault_ro)
        else $error("host write changed fault flags");

    property p_limit_set_pin_bad;
        @(posedge clk) disable iff (sys_rst)
        wr_go && (l_q.addr == ccr_pkg::OFS_ILIMIT) && limit_set_pin_out
            |=> (c_q.ilimit == 16'h0000) ##1 !c_q.charge_en;
    endproperty
    a_limit_set_pin_bad: assert property (p_limit_set_pin_bad)
        else $error("bad input limit not cleared");

    property p_block;
        @(posedge clk) disable iff (sys_rst)
        c_q.options[ccr_pkg::BIT_BLOCK] |=> !c_q.charge_en;
    endproperty
    a_block: assert property (p_block)
        else $error("charging while blocked");

    property p_oc_stop;
        @(posedge clk) disable iff (sys_rst)
        ev[ccr_pkg::FLT_IN_OC] |=> c_q.fault[ccr_pkg::FLT_IN_OC] && !c_q.charge_en [*8];
    endproperty
    a_oc_stop: assert property (p_oc_stop)
        else $error("overcurrent did not hold charging off");

    property p_temp_release;
        @(posedge clk) disable iff (sys_rst)
        c_q.pin_s2[ccr_pkg::PIN_COOL] && !ev[ccr_pkg::FLT_TEMP] |=> !c_q.fault[ccr_pkg::FLT_TEMP];
    endproperty
    a_temp_release: assert property (p_temp_release)
        else $error("thermal flag not released");

    property p_adapter_drop;
        @(posedge clk) disable iff (sys_rst)
        !c_q.pin_s2[ccr_pkg::PIN_ADAPTER] |=> !c_q.input_good ##1 !c_q.charge_en;
    endproperty
    a_adapter_drop: assert property (p_adapter_drop)
        else $error("input good held after adapter loss");

    property p_manual;
        @(posedge clk) disable iff (sys_rst)
        c_q.options[ccr_pkg::BIT_MANUAL] |=> (c_q.bat_sw == $past(c_q.options[ccr_pkg::BIT_BAT_DRV]))
            && (c_q.in_sw == $past(c_q.options[ccr_pkg::BIT_IN_DRV]));
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual switch drive not followed");

    property p_link_done;
        @(posedge link_clk) disable iff (l_q.rst_s2)
        l_q.done |-> !l_q.busy ##1 !l_q.done;
    endproperty
    a_link_done: assert property (p_link_done)
        else $error("link answer malformed");
endmodule

/* File: ccr_pkg.sv */
// shared constants for the charger control register bank
package ccr_pkg;
    // ==========================================
    // register offsets
    localparam logic [7:0] OFS_OPTIONS = 8'h12;
    localparam logic [7:0] OFS_FAULT = 8'h13;
    localparam logic [7:0] OFS_CURRENT = 8'h14;
    localparam logic [7:0] OFS_TARGET = 8'h15;
    localparam logic [7:0] OFS_ILIMIT = 8'h3f;

    // ==========================================
    // reset values and writable bit masks
    localparam logic [15:0] RST_OPTIONS = 16'h7101;
    localparam logic [15:0] RST_FAULT = 16'h0000;
    localparam logic [15:0] RST_CURRENT = 16'h0000;
    localparam logic [15:0] RST_TARGET = 16'h0000;
    localparam logic [15:0] RST_ILIMIT = 16'h2000;
    localparam logic [15:0] OPTIONS_WMASK = 16'hfff9;
    localparam logic [15:0] FAULT_MASK = 16'h07ff;
    localparam logic [15:0] CURRENT_MASK = 16'h3fc0;
    localparam logic [15:0] TARGET_MASK = 16'h7ffe;
    localparam logic [15:0] ILIMIT_MASK = 16'h3f80;
    localparam logic [15:0] ILIMIT_MIN = 16'h0080;
    localparam logic [15:0] ILIMIT_MAX = 16'h3f80;

    // ==========================================
    // option field positions
    localparam int unsigned BIT_DEGLITCH = 15;
    localparam int unsigned WD_HI = 14;
    localparam int unsigned WD_LO = 13;
    localparam int unsigned BIT_SLEEP_BAT = 12;
    localparam int unsigned BIT_RATE = 11;
    localparam int unsigned BIT_EMI_DIR = 10;
    localparam int unsigned BIT_SPREAD = 9;
    localparam int unsigned RECIRC_HI = 8;
    localparam int unsigned RECIRC_LO = 7;
    localparam int unsigned BIT_MONITOR = 6;
    localparam int unsigned BIT_MANUAL = 5;
    localparam int unsigned BIT_BAT_DRV = 4;
    localparam int unsigned BIT_IN_DRV = 3;
    localparam int unsigned BIT_CLEAR = 2;
    localparam int unsigned BIT_RSVD = 1;
    localparam int unsigned BIT_BLOCK = 0;

    // ==========================================
    // fault flag positions and synchronised pin vector layout
    localparam int unsigned FLT_TEMP = 10;
    localparam int unsigned FLT_IN_OC = 7;
    localparam int unsigned PIN_COOL = 11;
    localparam int unsigned PIN_ADAPTER = 12;
    localparam int unsigned PIN_SLEEP = 13;
    localparam int unsigned PIN_W = 14;

    // ==========================================
    // timing
    localparam int unsigned CLK_NS = 50;
    localparam int unsigned DEGLITCH_SLOW_MS = 250;
    localparam int unsigned DEGLITCH_FAST_US = 50;
    localparam int unsigned RECOVER_US = 2500;
    localparam longint unsigned WD_SHORT_S = 44;
    localparam longint unsigned WD_MID_S = 88;
    localparam longint unsigned WD_LONG_S = 175;
    localparam longint unsigned NS_PER_S = 64'd1000000000;
    // strictly under the fast deglitch time
    localparam int unsigned DEGLITCH_FAST_CYC = DEGLITCH_FAST_US * 1000 / CLK_NS - 1;
endpackage

/* File: ccr_host_model.sv */
// link-side host model that issues word requests to the register bank
`timescale 1ns/1ps
module ccr_host_model (
    input wire logic link_clk,
    output logic link_wr,
    output logic link_rd,
    output logic [7:0] link_addr,
    output logic [15:0] link_wdata,
    input wire logic [15:0] link_rdata,
    input wire logic link_done,
    input wire logic link_busy
);
    int gap = 0;

    // ==========================================
    // idle levels at time zero
    initial
    begin
        link_wr = 1'b0;
        link_rd = 1'b0;
        link_addr = 8'h00;
        link_wdata = 16'h0000;
    end

    // ==========================================
    // one request: a one-cycle pulse, then wait for the answer under a bound
    task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] wdata,
        output logic [15:0] rdata, output logic ok);
        int n;
        n = 0;
        // vary the spacing so prompt and slow requests both occur
        gap = (gap + 1) % 4;
        repeat (gap) @(posedge link_clk);
        @(posedge link_clk);
        link_wr <= wr;
        link_rd <= !wr;
        link_addr <= addr;
        link_wdata <= wdata;
        @(posedge link_clk);
        // strobes drop low; address and data lines show the inverse of the last value
        link_wr <= 1'b0;
        link_rd <= 1'b0;
        link_addr <= ~addr;
        link_wdata <= ~wdata;
        while (n < 40 && link_done !== 1'b1)
        begin
            @(posedge link_clk);
            n++;
        end
        rdata = link_rdata;
        ok = (link_done === 1'b1 && link_busy === 1'b0);
    endtask
endmodule

/* File: test_charger_control_registers.sv */
// self-checking bench for the charger control register bank
`timescale 1ns/1ps
module test_charger_control_registers;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic link_wr, link_rd, link_done, link_busy, ok;
    logic [7:0] link_addr;
    logic [15:0] link_wdata, link_rdata, rd, v;
    logic [10:0] hw_fault_event = 11'h000;
    logic temp_cool = 1'b0;
    logic adapter_level = 1'b0;
    logic sleep_mode = 1'b0;
    logic input_good_pin, charge_enable, soft_start, watchdog_expired, battery_switch;
    logic input_switch, switching_rate_select, spread_freq_enable, emi_shift_direction;
    logic monitor_source_select;
    logic [1:0] recirc_current_limit;
    logic [7:0] current_setting_field;
    logic [13:0] charge_target_field;
    logic [6:0] input_limit_field;
    logic [5:0] of;
    logic [31:0] lfsr = 32'h0684;
    logic [15:0] model [logic [7:0]];
    logic [7:0] adr [6] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h3f, 8'h20};
    logic [15:0] lim [5] = '{16'h0000, 16'h0080, 16'h3fc0, 16'h007f, 16'h3f80};
    int wdc [3] = '{100, 200, 300};
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    int starts = 0;
    int s0;

    // ==========================================
    // clocks, unrelated in phase
    initial forever #25 clk = ~clk;
    initial
    begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end

    // ==========================================
    // design with short counts, and the host model
    ccr_regs #(.DEGLITCH_SLOW_CYC(32'd40), .RECOVER_CYC(32'd20), .WD_SHORT_CYC(32'd100),
        .WD_MID_CYC(32'd200), .WD_LONG_CYC(32'd300)) u_ccr_regs (
        .clk, .sys_rst, .link_clk, .link_wr, .link_rd, .link_addr, .link_wdata, .link_rdata,
        .link_done, .link_busy, .hw_fault_event, .temp_cool, .adapter_level, .sleep_mode,
        .input_good_pin, .charge_enable, .soft_start, .watchdog_expired, .battery_switch,
        .input_switch, .switching_rate_select, .spread_freq_enable, .emi_shift_direction,
        .recirc_current_limit, .monitor_source_select, .current_setting_field,
        .charge_target_field, .input_limit_field);
    ccr_host_model u_ccr_host_model (.link_clk, .link_wr, .link_rd, .link_addr, .link_wdata,
        .link_rdata, .link_done, .link_busy);

    // ==========================================
    // restart pulse count and hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (soft_start === 1'b1)
            starts <= starts + 1;
        if (cyc == 10000)
        begin
            failures++;
            results();
        end
    end

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0];
    endfunction

    task automatic wclk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_ccr_host_model.access(1'b1, a, d, rd, ok);
        chk("write answered", 16'h1, 16'(ok));
        if (a == 8'h12)
            model[a] = d & 16'hfff9;
        if (a == 8'h12 && d[2])
            model[8'h13] = 16'h0000;
        if (a == 8'h14)
            model[a] = d & 16'h3fc0;
        if (a == 8'h15)
            model[a] = d & 16'h7ffe;
        if (a == 8'h3f)
            model[a] = (d < 16'h0080 || d > 16'h3f80) ? 16'h0000 : d & 16'h3f80;
    endtask

    task automatic rdc(input logic [7:0] a);
        u_ccr_host_model.access(1'b0, a, 16'h0000, rd, ok);
        chk($sformatf("register %h", a), model.exists(a) ? model[a] : 16'h0000, rd);
    endtask

    task automatic results();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial
    begin
        model = '{8'h12: 16'h7101, 8'h13: 16'h0000, 8'h14: 16'h0000, 8'h15: 16'h0000,
            8'h3f: 16'h2000};
        wclk(4);
        sys_rst <= 1'b0;
        repeat (10) @(posedge link_clk);
        foreach (adr[i]) rdc(adr[i]);
        chk("reset fields", 16'h0140, 16'({recirc_current_limit, input_limit_field}));
        repeat (6)
        begin
            wr(8'h12, rnd() & 16'h9fff);
            wr(8'h14, rnd());
            wr(8'h15, rnd());
            v = rnd() & 16'h3f80;
            wr(8'h3f, v | 16'h0080);
            wr(8'h13, rnd());
            // unmapped offset takes no write and keeps reading zero
            wr(8'h20, rnd());
            wclk(3);
            foreach (adr[i]) rdc(adr[i]);
            v = model[8'h12];
            of = {switching_rate_select, emi_shift_direction, spread_freq_enable,
                recirc_current_limit, monitor_source_select};
            chk("option fields", 16'(v[11:6]), 16'(of));
            chk("current field", 16'(model[8'h14][13:6]), 16'(current_setting_field));
            chk("target field", 16'(model[8'h15][14:1]), 16'(charge_target_field));
            chk("limit field", 16'(model[8'h3f][13:7]), 16'(input_limit_field));
        end
        wr(8'h12, 16'h0000);
        wclk(1);
        adapter_level <= 1'b1;
        wclk(30);
        chk("good slow early", 16'h0, 16'(input_good_pin));
        wclk(20);
        chk("good slow", 16'h1, 16'(input_good_pin));
        adapter_level <= 1'b0;
        wclk(4);
        chk("good drop", 16'h0, 16'(input_good_pin));
        wr(8'h12, 16'h8000);
        wclk(1);
        adapter_level <= 1'b1;
        wclk(1004);
        chk("good fast", 16'h1, 16'(input_good_pin));
        chk("charge on", 16'h1, 16'(charge_enable));
        wr(8'h12, 16'h8001);
        wclk(3);
        chk("charge blocked", 16'h0, 16'(charge_enable));
        chk("auto switches", 16'h1, 16'({battery_switch, input_switch}));
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h12, 16'h8020 | 16'(k << 3));
            wclk(3);
            chk("manual switches", 16'(k), 16'({battery_switch, input_switch}));
        end
        wr(8'h12, 16'h9000);
        wclk(1);
        sleep_mode <= 1'b1;
        wclk(4);
        chk("sleep switches", 16'h2, 16'({battery_switch, input_switch}));
        wr(8'h12, 16'h8000);
        wclk(3);
        chk("sleep switches off", 16'h0, 16'({battery_switch, input_switch}));
        sleep_mode <= 1'b0;
        foreach (lim[i])
        begin
            wr(8'h3f, lim[i]);
            wclk(3);
            rdc(8'h3f);
            chk("charge vs limit", 16'(model[8'h3f] != 0), 16'(charge_enable));
        end
        wclk(1);
        v = rnd() & 16'h03ff | 16'h0080;
        hw_fault_event <= v[10:0];
        model[8'h13] = v;
        wclk(6);
        chk("charge in fault", 16'h0, 16'(charge_enable));
        rdc(8'h13);
        wr(8'h13, 16'h0000);
        rdc(8'h13);
        s0 = starts;
        wclk(1);
        hw_fault_event <= 11'h000;
        wclk(12);
        chk("charge held off", 16'h0, 16'(charge_enable));
        wclk(20);
        chk("charge restarted", 16'h1, 16'(charge_enable));
        chk("soft start seen", 16'h1, 16'(starts != s0));
        wclk(1);
        hw_fault_event <= 11'h400;
        model[8'h13][10] = 1'b1;
        wclk(6);
        chk("charge hot", 16'h0, 16'(charge_enable));
        hw_fault_event <= 11'h000;
        wclk(6);
        rdc(8'h13);
        wclk(1);
        temp_cool <= 1'b1;
        model[8'h13][10] = 1'b0;
        wclk(6);
        rdc(8'h13);
        wr(8'h12, 16'h8004);
        rdc(8'h13);
        rdc(8'h12);
        wclk(400);
        chk("watchdog off", 16'h0, 16'(watchdog_expired));
        foreach (wdc[i])
        begin
            wr(8'h12, 16'h8000 | 16'((i + 1) << 13));
            wclk(wdc[i] * 4 / 5);
            chk("watchdog early", 16'h0, 16'(watchdog_expired));
            wclk(wdc[i] * 2 / 5);
            chk("watchdog expired", 16'h1, 16'(watchdog_expired));
            chk("charge stopped", 16'h0, 16'(charge_enable));
        end
        results();
    end
endmodule
